// [sadc_pkg.sv]
// Operation
// R1: chip select falling resets interface counters and enables serial in, out and clock.
// R2: chip select rising stops accepting serial input and shift clock.
// R3: serial output floats while chip select high, driven while low.
// R4: input byte arrives msb first; first four rising edges capture the command.
// R5: next four rising edges shift in configuration data.
// R6: first result bit appears as soon as chip select goes low.
// R7: each later falling shift clock edge presents the next result bit.
// R8: link is clock idle low, rising edge sample, at most 15 MHz; the host model clocks it at about 20.8 MHz.
// R9: end-of-conversion mode drives status pin high when conversion completes.
// R10: interrupt mode drives status pin low when conversion completes.
// R11: command selects one of 11 inputs or three self-test voltages.
// R12: reference configuration picks 2.048 V, 4.096 V or external reference.
// R13: order, output length, unipolar/bipolar coding and power-down are configurable.
// R14: interrupt mode clears the low status on the next rising shift clock.
// R15: end-of-conversion mode drives status low after last falling edge until done.
// R16: sampling runs from fourth falling edge until last falling edge.
// R17: last falling edge hands control to the internal conversion sequencer.
package sadc_pkg;
  localparam int CLK_PERIOD_NS = 100;
  localparam int SHIFT_CLK_MAX_MHZ = 15;
  localparam int CONV_TIME_NS = 2000;
  localparam int CONV_CYCLES = (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int BYTE_BITS = 8;
  localparam int CMD_BITS = 4;
  localparam int RESULT_BITS = 12;
  localparam int WORD_BITS = 16;
  localparam logic [4:0] SAMPLE_START_EDGE = 5'h04;
  localparam logic [3:0] CMD_EDGE_IDX = 4'h3;
  localparam logic [3:0] BYTE_EDGE_IDX = 4'h7;
  localparam logic [3:0] LAST_CHAN = 4'hd;
  localparam logic [3:0] CMD_CFG1 = 4'he;
  localparam logic [3:0] CMD_CFG2 = 4'hf;
  localparam int CFG1_ORDER_BIT = 0;
  localparam int CFG1_LEN_LSB = 1;
  localparam int CFG1_BIPOLAR_BIT = 3;
  localparam int CFG2_REF_LSB = 0;
  localparam int CFG2_PD_BIT = 2;
  localparam int CFG2_INT_BIT = 3;
  localparam logic [1:0] LEN_12 = 2'h0;
  localparam logic [1:0] LEN_8 = 2'h1;
  localparam logic [1:0] LEN_16 = 2'h2;
  localparam logic [1:0] REF_EXT = 2'h0;
  localparam logic [1:0] REF_2V048 = 2'h1;
  localparam logic [1:0] REF_4V096 = 2'h2;
  localparam logic [11:0] BIPOLAR_FLIP = 12'h800;
  localparam logic [3:0] RST_CHAN = 4'h0;
  typedef enum logic [0:0] {ST_IDLE, ST_CONV} sadc_state_t;
endpackage

// [sadc_fifo_if.sv]
`timescale 1ns/1ps
interface sadc_fifo_if #(parameter int WIDTH = 8);
  logic pushValid;
  logic pushReady;
  logic [WIDTH-1:0] pushData;
  logic popValid;
  logic popReady;
  logic [WIDTH-1:0] popData;
  modport fifo (input pushValid, input pushData, output pushReady, output popValid, output popData, input popReady);
  modport user (output pushValid, output pushData, input pushReady, input popValid, input popData, output popReady);
endinterface

// [sadc_fifo.sv]
`timescale 1ns/1ps
module sadc_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 2
) (
  input wire logic clock,
  input wire logic reset,
  sadc_fifo_if.fifo bus
);
  localparam int PW = $clog2(DEPTH);
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PW-1:0] wrPtr;
    logic [PW-1:0] rdPtr;
    logic [PW:0] count;
  } sadc_fifo_state_t;
  sadc_fifo_state_t stateFf;
  sadc_fifo_state_t nxtState;
  logic doPush;
  logic doPop;

  // pointer wrap shared by both ends
  function automatic logic [PW-1:0] bump(input logic [PW-1:0] p);
    bump = (p == PW'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction

  // honest flags straight from the occupancy count
  assign bus.pushReady = (stateFf.count != (PW+1)'(DEPTH));
  assign bus.popValid = (stateFf.count != '0);
  assign bus.popData = stateFf.mem[stateFf.rdPtr];
  assign doPush = bus.pushValid && bus.pushReady;
  assign doPop = bus.popReady && bus.popValid;

  always_comb
  begin
    nxtState = stateFf;
    if (doPush)
    begin
      nxtState.mem[stateFf.wrPtr] = bus.pushData;
      nxtState.wrPtr = bump(stateFf.wrPtr);
    end
    if (doPop)
    begin
      nxtState.rdPtr = bump(stateFf.rdPtr);
    end
    nxtState.count = stateFf.count + (PW+1)'(doPush) - (PW+1)'(doPop);
  end

  always_ff @(posedge clock)
  begin
    if (reset)
      stateFf <= '0;
    else
      stateFf <= nxtState;
  end
endmodule

// [sadc_top.sv]
`timescale 1ns/1ps
module sadc_top #(
  parameter int CONV_CYCLES = sadc_pkg::CONV_CYCLES
) (
  input wire logic clock,
  input wire logic reset,
  input wire logic shiftClock,
  input wire logic chipSelectN,
  input wire logic serialInLine,
  input wire logic [11:0] sampleValue,
  output logic serialOut,
  output logic serialOutEnN,
  output logic statusPin,
  output logic [3:0] channelSelect,
  output logic [1:0] referenceConfig,
  output logic powerDown,
  output logic samplingActive,
  output logic convertActive
);
  // ---- link domain, clocked by the host's shift clock ----
  typedef struct packed {
    logic [3:0] riseCnt;
    logic [7:0] rxShift;
    logic [3:0] commandLatch;
  } sadc_rise_t;
  typedef struct packed {
    logic riseTog;
    logic [7:0] rxByte;
  } sadc_rhold_t;
  typedef struct packed {
    logic [4:0] txCnt;
    logic sampling;
  } sadc_fall_t;
  typedef struct packed {
    logic frameTog;
  } sadc_fhold_t;

  sadc_rise_t riseFf;
  sadc_rise_t nxtRise;
  sadc_rhold_t rholdFf;
  sadc_rhold_t nxtRhold;
  sadc_fall_t fallFf;
  sadc_fall_t nxtFall;
  sadc_fhold_t fholdFf;
  sadc_fhold_t nxtFhold;

  // ---- main domain state ----
  typedef struct packed {
    logic [1:0] csSync;
    logic [2:0] frameSync;
    logic [2:0] riseSync;
    logic [1:0][7:0] byteSync;
    logic [1:0][11:0] sampleSync;
    logic lastFrameTog;
    logic orderLsb;
    logic [1:0] lenCode;
    logic bipolar;
    logic [1:0] refSel;
    logic pd;
    logic intMode;
    logic [3:0] chan;
    sadc_pkg::sadc_state_t state;
    logic [15:0] convCnt;
    logic [11:0] result;
    logic [15:0] outWord;
    logic [4:0] outLen;
    logic status;
    logic convDone;
  } sadc_main_t;

  sadc_main_t mainFf;
  sadc_main_t nxtMain;
  logic frameEvent;
  logic riseEvent;
  logic [3:0] popCmd;
  logic [3:0] popCfg;

  sadc_fifo_if #(.WIDTH(sadc_pkg::BYTE_BITS)) cmdBus ();

  // decoded output length in bits
  function automatic logic [4:0] lenOf(input logic [1:0] code);
    case (code)
      sadc_pkg::LEN_8: lenOf = 5'h08;
      sadc_pkg::LEN_16: lenOf = 5'h10;
      default: lenOf = 5'h0c;
    endcase
  endfunction

  // bit reversal for lsb-first delivery
  function automatic logic [11:0] rev12(input logic [11:0] v);
    for (int i = 0; i < sadc_pkg::RESULT_BITS; i++)
      rev12[i] = v[sadc_pkg::RESULT_BITS-1-i];
  endfunction

  // rising edges: command nibble then config nibble, msb first
  always_comb
  begin
    nxtRise = riseFf;
    nxtRhold = rholdFf;
    // one toggle per frame, on its first rising edge: a toggle per edge would
    // outrun the main clock and vanish in the synchroniser
    if (!chipSelectN && riseFf.riseCnt == '0)
      nxtRhold.riseTog = ~rholdFf.riseTog; // R14 R2
    if (riseFf.riseCnt <= sadc_pkg::BYTE_EDGE_IDX)
    begin
      nxtRise.rxShift = {riseFf.rxShift[6:0], serialInLine}; // R4 R8
      nxtRise.riseCnt = riseFf.riseCnt + 4'h1;
    end
    if (riseFf.riseCnt == sadc_pkg::CMD_EDGE_IDX)
      nxtRise.commandLatch = {riseFf.rxShift[2:0], serialInLine}; // R4
    if (riseFf.riseCnt == sadc_pkg::BYTE_EDGE_IDX)
      nxtRhold.rxByte = {riseFf.commandLatch, riseFf.rxShift[2:0], serialInLine}; // R5
  end

  // chip select high holds the counters cleared and ignores the clock
  always_ff @(posedge shiftClock or posedge chipSelectN)
  begin
    if (chipSelectN)
      riseFf <= '0; // R1 R2
    else
      riseFf <= nxtRise;
  end

  // the captured byte and the edge toggle must outlive the frame
  always_ff @(posedge shiftClock or posedge reset)
  begin
    if (reset)
      rholdFf <= '0;
    else
      rholdFf <= nxtRhold;
  end

  // falling edges: advance output, track sampling window and frame end
  always_comb
  begin
    nxtFall = fallFf;
    nxtFhold = fholdFf;
    if (fallFf.txCnt < mainFf.outLen)
    begin
      nxtFall.txCnt = fallFf.txCnt + 5'h01; // R7
      nxtFall.sampling = (nxtFall.txCnt >= sadc_pkg::SAMPLE_START_EDGE) && (nxtFall.txCnt < mainFf.outLen); // R16
      if (nxtFall.txCnt == mainFf.outLen)
        nxtFhold.frameTog = ~fholdFf.frameTog; // R17
    end
  end

  always_ff @(negedge shiftClock or posedge chipSelectN)
  begin
    if (chipSelectN)
      fallFf <= '0; // R1 R2
    else
      fallFf <= nxtFall;
  end

  always_ff @(negedge shiftClock or posedge reset)
  begin
    if (reset)
      fholdFf <= '0;
    else
      fholdFf <= nxtFhold;
  end

  // the pad must follow chip select without waiting for any clock edge,
  // so the bit is a mux of held flops and the enable is chip select itself, neither a flop of its own
  assign serialOut = (fallFf.txCnt < 5'h10) ? mainFf.outWord[4'hf - fallFf.txCnt[3:0]] : 1'b0; // R6 R7
  assign serialOutEnN = chipSelectN; // R3
  assign samplingActive = fallFf.sampling;

  // ---- main domain ----
  sadc_fifo #(
    .WIDTH(sadc_pkg::BYTE_BITS),
    .DEPTH(2)
  ) u_cmd_fifo (
    .clock(clock),
    .reset(reset),
    .bus(cmdBus)
  );

  // edges seen after the synchronisers, never on the first stage
  assign frameEvent = mainFf.frameSync[2] != mainFf.frameSync[1];
  assign riseEvent = mainFf.riseSync[2] != mainFf.riseSync[1];
  // a frame stays pending until the buffer takes it, so a full buffer stalls here
  assign cmdBus.pushValid = mainFf.frameSync[2] != mainFf.lastFrameTog;
  assign cmdBus.pushData = mainFf.byteSync[1];
  assign cmdBus.popReady = (mainFf.state == sadc_pkg::ST_IDLE);
  assign popCmd = cmdBus.popData[7:4];
  assign popCfg = cmdBus.popData[3:0];

  always_comb
  begin
    nxtMain = mainFf;
    nxtMain.csSync = {mainFf.csSync[0], chipSelectN};
    nxtMain.frameSync = {mainFf.frameSync[1:0], fholdFf.frameTog};
    nxtMain.riseSync = {mainFf.riseSync[1:0], rholdFf.riseTog};
    nxtMain.byteSync = {mainFf.byteSync[0], rholdFf.rxByte};
    nxtMain.sampleSync = {mainFf.sampleSync[0], sampleValue};
    nxtMain.convDone = 1'b0;
    if (cmdBus.pushValid && cmdBus.pushReady)
      nxtMain.lastFrameTog = mainFf.frameSync[2];
    // interrupt low status clears, pin back high, on the next rising shift clock
    if (mainFf.intMode && riseEvent)
      nxtMain.status = 1'b1; // R14
    // end-of-conversion goes busy once the frame's last edge is seen
    if (!mainFf.intMode && frameEvent)
      nxtMain.status = 1'b0; // R15
    case (mainFf.state)
      sadc_pkg::ST_IDLE:
      begin
        if (cmdBus.popValid)
        begin
          if (popCmd <= sadc_pkg::LAST_CHAN)
            nxtMain.chan = popCmd; // R11
          else if (popCmd == sadc_pkg::CMD_CFG1)
          begin
            nxtMain.orderLsb = popCfg[sadc_pkg::CFG1_ORDER_BIT]; // R13
            nxtMain.lenCode = popCfg[sadc_pkg::CFG1_LEN_LSB +: 2]; // R13
            nxtMain.bipolar = popCfg[sadc_pkg::CFG1_BIPOLAR_BIT]; // R13
          end
          else
          begin
            nxtMain.refSel = popCfg[sadc_pkg::CFG2_REF_LSB +: 2]; // R12
            nxtMain.pd = popCfg[sadc_pkg::CFG2_PD_BIT]; // R13
            nxtMain.intMode = popCfg[sadc_pkg::CFG2_INT_BIT]; // R9 R10
          end
          // power-down suppresses the conversion this frame would start
          if (!(popCmd == sadc_pkg::CMD_CFG2 && popCfg[sadc_pkg::CFG2_PD_BIT]))
          begin
            nxtMain.state = sadc_pkg::ST_CONV; // R17
            nxtMain.convCnt = 16'(CONV_CYCLES - 1);
          end
        end
      end
      sadc_pkg::ST_CONV:
      begin
        if (mainFf.convCnt == '0)
        begin
          nxtMain.state = sadc_pkg::ST_IDLE;
          nxtMain.convDone = 1'b1;
          nxtMain.result = mainFf.bipolar ? (mainFf.sampleSync[1] ^ sadc_pkg::BIPOLAR_FLIP)
            : mainFf.sampleSync[1]; // R13
          nxtMain.status = ~mainFf.intMode; // R9 R10
        end
        else
          nxtMain.convCnt = mainFf.convCnt - 16'h0001;
      end
      default: nxtMain.state = sadc_pkg::ST_IDLE;
    endcase
    // the link reads the word only while chip select is low, so it may change
    // only while chip select is seen high; a result landing mid-frame waits
    if (mainFf.csSync[1])
    begin
      nxtMain.outWord = {(mainFf.orderLsb ? rev12(mainFf.result) : mainFf.result), 4'h0}; // R6
      nxtMain.outLen = lenOf(mainFf.lenCode);
    end
  end

  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      mainFf <= '0;
      mainFf.csSync <= 2'h3;
      mainFf.status <= 1'b1;
      mainFf.outLen <= 5'h0c;
      mainFf.chan <= sadc_pkg::RST_CHAN;
      mainFf.refSel <= sadc_pkg::REF_EXT;
      mainFf.state <= sadc_pkg::ST_IDLE;
    end
    else
      mainFf <= nxtMain;
  end

  assign statusPin = mainFf.status;
  assign channelSelect = mainFf.chan;
  assign referenceConfig = mainFf.refSel;
  assign powerDown = mainFf.pd;
  assign convertActive = (mainFf.state == sadc_pkg::ST_CONV);

  // ---- checks ----
  property p_eoc_done;
    @(posedge clock) disable iff (reset)
    (mainFf.convDone && !mainFf.intMode) |-> statusPin ##1 (statusPin || frameEvent);
  endproperty
  a_eoc_done: assert property (p_eoc_done) else $error("status not high after conversion in eoc mode"); // R9

  property p_int_done;
    @(posedge clock) disable iff (reset)
    (mainFf.convDone && mainFf.intMode) |-> !statusPin;
  endproperty
  a_int_done: assert property (p_int_done) else $error("status not low after conversion in int mode"); // R10

  property p_int_clear;
    @(posedge clock) disable iff (reset)
    (mainFf.intMode && riseEvent && !nxtMain.convDone) |=> statusPin;
  endproperty
  a_int_clear: assert property (p_int_clear) else $error("interrupt not cleared by shift clock"); // R14

  property p_eoc_busy;
    @(posedge clock) disable iff (reset)
    (!mainFf.intMode && frameEvent && !nxtMain.convDone) |=> !statusPin;
  endproperty
  a_eoc_busy: assert property (p_eoc_busy) else $error("eoc not low after frame end"); // R15

  property p_chan_sel;
    @(posedge clock) disable iff (reset)
    (cmdBus.popValid && cmdBus.popReady && popCmd <= sadc_pkg::LAST_CHAN) |=> channelSelect == $past(popCmd);
  endproperty
  a_chan_sel: assert property (p_chan_sel) else $error("channel not taken from command"); // R11

  property p_ref_sel;
    @(posedge clock) disable iff (reset)
    (cmdBus.popValid && cmdBus.popReady && popCmd == sadc_pkg::CMD_CFG2) |=> referenceConfig == $past(popCfg[1:0]);
  endproperty
  a_ref_sel: assert property (p_ref_sel) else $error("reference not taken from config"); // R12

  property p_conv_len;
    @(posedge clock) disable iff (reset)
    $rose(convertActive) |-> convertActive[*2] ##[0:1000] mainFf.convDone;
  endproperty
  a_conv_len: assert property (p_conv_len) else $error("conversion did not run and finish"); // R17

  property p_frame_push;
    @(posedge clock) disable iff (reset)
    (cmdBus.pushValid && cmdBus.pushReady) |=> !cmdBus.pushValid;
  endproperty
  a_frame_push: assert property (p_frame_push) else $error("frame byte pushed twice"); // R5

  property p_pd_hold;
    @(posedge clock) disable iff (reset)
    (powerDown && !convertActive && !cmdBus.popValid) |=> !convertActive;
  endproperty
  a_pd_hold: assert property (p_pd_hold) else $error("conversion started without command"); // R13

  property p_sample_win;
    @(negedge shiftClock) disable iff (chipSelectN)
    (fallFf.txCnt >= sadc_pkg::SAMPLE_START_EDGE && fallFf.txCnt < mainFf.outLen) |-> samplingActive;
  endproperty
  a_sample_win: assert property (p_sample_win) else $error("input not sampled inside window"); // R16

  c_eoc: cover property (@(posedge clock) disable iff (reset) mainFf.convDone && !mainFf.intMode);
  c_int: cover property (@(posedge clock) disable iff (reset) mainFf.convDone ##[1:200] (mainFf.intMode && riseEvent));
  c_full: cover property (@(posedge clock) disable iff (reset) cmdBus.pushValid && !cmdBus.pushReady);
  c_len8: cover property (@(posedge clock) disable iff (reset) frameEvent && mainFf.outLen == 5'h08);
  c_len16: cover property (@(posedge clock) disable iff (reset) frameEvent && mainFf.outLen == 5'h10);
endmodule

// [sadc_host.sv]
`timescale 1ns/1ps
// host serial port model: clock idle low, data set before each rising edge
module sadc_host #(
  parameter int HALF_NS = 24
) (
  output logic shiftClock,
  output logic chipSelectN,
  output logic serialInLine,
  input wire logic serialOut,
  input wire logic serialOutEnN
);
  logic [11:0] word;
  event frameDone;

  // link idle: clock low, not selected
  initial
  begin
    shiftClock = 1'b0;
    chipSelectN = 1'b1;
    serialInLine = 1'b1;
  end

  // one frame of nEdge pulses; frames of at least eight pulses report their word
  task automatic frame(input logic [7:0] cmd, input int nEdge);
    // keep the link off the main clock's edges
    #7;
    chipSelectN = 1'b0;
    word = 12'h000;
    #(HALF_NS);
    for (int i = 0; i < nEdge; i++)
    begin
      serialInLine = (i < 8) ? cmd[7 - i] : ~serialInLine;
      #(HALF_NS);
      shiftClock = 1'b1;
      word = {word[10:0], serialOut};
      #(HALF_NS);
      shiftClock = 1'b0;
    end
    #(HALF_NS);
    chipSelectN = 1'b1;
    // released line: show the inverse, not a stale level
    serialInLine = ~serialInLine;
    if (nEdge >= 8)
      -> frameDone;
  endtask

  // deliberate pulses while deselected, the device must ignore them
  task automatic stray();
    #7;
    for (int i = 0; i < 8; i++)
    begin
      serialInLine = ~serialInLine;
      #(HALF_NS) shiftClock = 1'b1;
      #(HALF_NS) shiftClock = 1'b0;
    end
  endtask
endmodule

// [test_sadc_top.sv]
`timescale 1ns/1ps
`define CHK(nm, exp, got) \
  begin \
    nCompared++; \
    if ((got) !== (exp)) \
    begin \
      failCount++; \
      $display("ERROR %s expected %h seen %h", nm, exp, got); \
    end \
  end
module test_sadc_top;
  localparam int CONV = 4;
  logic clock = 1'b0;
  logic reset = 1'b1;
  logic [11:0] sampleValue = 12'h000;
  logic shiftClock, chipSelectN, serialInLine, serialOut, serialOutEnN, statusPin;
  logic [3:0] channelSelect;
  logic [1:0] referenceConfig;
  logic powerDown, samplingActive, convertActive;
  int failCount = 0;
  int nCompared = 0;
  int nFall = 0;
  int rnd;
  logic [11:0] expq[$];
  logic [11:0] expWord;
  logic [11:0] lastRes = 12'h000;
  logic lsbFirst = 1'b0;
  logic bipolar = 1'b0;
  logic intMode = 1'b0;
  int frameLen = 12;

  sadc_top #(.CONV_CYCLES(CONV)) dut (.clock(clock), .reset(reset), .shiftClock(shiftClock),
    .chipSelectN(chipSelectN), .serialInLine(serialInLine), .sampleValue(sampleValue),
    .serialOut(serialOut), .serialOutEnN(serialOutEnN), .statusPin(statusPin),
    .channelSelect(channelSelect), .referenceConfig(referenceConfig), .powerDown(powerDown),
    .samplingActive(samplingActive), .convertActive(convertActive));

  sadc_host host (.shiftClock(shiftClock), .chipSelectN(chipSelectN), .serialInLine(serialInLine),
    .serialOut(serialOut), .serialOutEnN(serialOutEnN));

  // main clock
  always #50 clock = ~clock;

  // pad enable follows chip select at every rising shift edge, selected or not
  always @(posedge shiftClock)
    `CHK("serialOutEnN", chipSelectN, serialOutEnN)

  // falling-edge count per frame; sampling window is edges 4 to frameLen - 1
  always @(negedge chipSelectN)
    nFall = 0;
  always @(negedge shiftClock)
  begin
    if (!chipSelectN)
    begin
      nFall++;
      #5;
      `CHK("samplingActive", logic'(nFall >= 4 && nFall < frameLen), samplingActive)
    end
  end

  // each full frame hands back a word; match it to the oldest note
  always @(host.frameDone)
  begin
    expWord = expq.pop_front();
    `CHK("serialWord", expWord, host.word)
  end

  function automatic logic [11:0] rev12(input logic [11:0] v);
    logic [11:0] r;
    for (int i = 0; i < 12; i++)
      r[i] = v[11 - i];
    return r;
  endfunction

  // bounded poll, sampled just after the edge so updates have landed
  task automatic waitFor(input int sel, input logic lvl, input string nm);
    int n;
    n = 0;
    while (((sel == 0) ? statusPin : convertActive) !== lvl && n < 40)
    begin
      @(posedge clock);
      #1;
      n++;
    end
    `CHK(nm, lvl, (sel == 0) ? statusPin : convertActive)
  endtask

  // one byte frame plus the conversion it starts
  task automatic run(input logic [3:0] cmd, input logic [3:0] cfg);
    logic wasInt;
    logic conv;
    logic [11:0] ord;
    wasInt = intMode;
    conv = !(cmd == sadc_pkg::CMD_CFG2 && cfg[2]);
    ord = lsbFirst ? rev12(lastRes) : lastRes;
    // short frames keep the leading bits, long ones shift the padding in
    if (frameLen == 8)
      expq.push_back({4'h0, ord[11:4]});
    else if (frameLen == 16)
      expq.push_back({ord[7:0], 4'h0});
    else
      expq.push_back(ord);
    @(posedge clock);
    sampleValue <= 12'($urandom);
    @(posedge clock);
    host.frame({cmd, cfg}, frameLen);
    #1;
    if (wasInt)
      `CHK("statusCleared", 1'b1, statusPin)
    if (cmd == sadc_pkg::CMD_CFG1)
    begin
      lsbFirst = cfg[0];
      bipolar = cfg[3];
      frameLen = (cfg[2:1] == sadc_pkg::LEN_8) ? 8 : (cfg[2:1] == sadc_pkg::LEN_16) ? 16 : 12;
    end
    if (cmd == sadc_pkg::CMD_CFG2)
      intMode = cfg[3];
    if (conv)
    begin
      // coding is applied when the sample is converted
      lastRes = sampleValue ^ (bipolar ? sadc_pkg::BIPOLAR_FLIP : 12'h000);
      waitFor(1, 1'b1, "convertActive");
      // busy follows the mode in force when the frame ended
      if (!wasInt)
        waitFor(0, 1'b0, "statusBusy");
      waitFor(0, intMode ? 1'b0 : 1'b1, "statusDone");
    end
    else
    begin
      repeat (20) @(posedge clock);
      #1;
      `CHK("convertActive", 1'b0, convertActive)
    end
    // gap of at least four clocks before the next frame
    repeat (5) @(posedge clock);
  endtask

  task automatic wrapUp();
    $display("compared %0d mismatches %0d", nCompared, failCount);
    if (failCount == 0 && nCompared > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // watchdog, well past the expected run of about 80 us
  initial
  begin
    #2000000;
    failCount++;
    wrapUp();
  end

  // test sequence
  initial
  begin
    rnd = $urandom(32'he97f);
    repeat (10) @(posedge clock);
    reset <= 1'b0;
    repeat (4) @(posedge clock);
    #1;
    `CHK("statusPin", 1'b1, statusPin)
    `CHK("channelSelect", 4'h0, channelSelect)
    `CHK("referenceConfig", 2'h0, referenceConfig)
    `CHK("powerDown", 1'b0, powerDown)
    `CHK("serialOutEnN", 1'b1, serialOutEnN)
    for (int ch = 0; ch <= 13; ch++)
    begin
      run(4'(ch), 4'($urandom));
      `CHK("channelSelect", 4'(ch), channelSelect)
    end
    for (int r = 0; r <= 2; r++)
    begin
      run(sadc_pkg::CMD_CFG2, {2'b00, 2'(r)});
      `CHK("referenceConfig", 2'(r), referenceConfig)
    end
    // lsb first, then bipolar coding, then back to defaults
    run(sadc_pkg::CMD_CFG1, 4'h1);
    run(4'h3, 4'($urandom));
    run(sadc_pkg::CMD_CFG1, 4'h8);
    run(4'h5, 4'($urandom));
    run(sadc_pkg::CMD_CFG1, 4'h0);
    // short and long output words
    run(sadc_pkg::CMD_CFG1, 4'h2);
    run(4'h6, 4'($urandom));
    run(sadc_pkg::CMD_CFG1, 4'h4);
    run(4'hc, 4'($urandom));
    run(sadc_pkg::CMD_CFG1, 4'h0);
    // interrupt-style status, cleared by the next frame
    run(sadc_pkg::CMD_CFG2, 4'h8);
    run(4'h2, 4'($urandom));
    run(4'h7, 4'($urandom));
    run(sadc_pkg::CMD_CFG2, 4'h0);
    // power down starts no conversion
    run(sadc_pkg::CMD_CFG2, 4'h4);
    `CHK("powerDown", 1'b1, powerDown)
    run(sadc_pkg::CMD_CFG2, 4'h0);
    `CHK("powerDown", 1'b0, powerDown)
    // pulses while deselected change nothing
    host.stray();
    repeat (5) @(posedge clock);
    #1;
    `CHK("channelSelect", 4'h7, channelSelect)
    // aborted frame, then a clean one must decode from bit one
    host.frame(8'hb6, 3);
    repeat (5) @(posedge clock);
    run(4'h9, 4'($urandom));
    `CHK("channelSelect", 4'h9, channelSelect)
    wrapUp();
  end
endmodule
